/* shared/vcmp_pkg.sv */
// Package for the voltage comparator control block: register map, fields, reset values and enums.
// Assumes byte offsets on a 32-bit APB bus, one aligned word per register.
package vcmp_pkg;

   // Register word indices (printed offsets index bytes, so each byte offset is index times four).
   localparam logic [3:0] VCMP_IDX_CTRL   = 4'h0;
   localparam logic [3:0] VCMP_IDX_MUX    = 4'h2;
   localparam logic [3:0] VCMP_IDX_IRQEN  = 4'h6;
   localparam logic [3:0] VCMP_IDX_STATUS = 4'h7;
   localparam logic [3:0] VCMP_IDX_SLEEP  = 4'h8;
   localparam int         VCMP_INST_STRIDE_IDX = 16;

   // Control word A fields.
   localparam int VCMP_CTRL_ENABLE_BIT  = 0;
   localparam int VCMP_CTRL_HYS_LSB     = 1;
   localparam int VCMP_CTRL_EDGE_LSB    = 4;
   localparam int VCMP_CTRL_PADEN_BIT   = 6;
   localparam int VCMP_CTRL_STDBY_BIT   = 7;
   // Input select word fields.
   localparam int VCMP_MUX_NEG_LSB      = 0;
   localparam int VCMP_MUX_POS_LSB      = 3;
   localparam int VCMP_MUX_INV_BIT      = 7;
   // Irq enable and status fields.
   localparam int VCMP_IRQEN_BIT        = 0;
   localparam int VCMP_STAT_FLAG_BIT    = 0;
   localparam int VCMP_STAT_STATE_BIT   = 4;

   localparam logic [7:0] VCMP_CTRL_RST  = 8'h00;
   localparam logic [7:0] VCMP_MUX_RST   = 8'h00;
   localparam logic [7:0] VCMP_IRQEN_RST = 8'h00;
   localparam logic [1:0] VCMP_SLEEP_RST = 2'h0;

   localparam int VCMP_NUM_INST = 3;
   localparam int VCMP_SYNC_CYCLES = 3;

   typedef enum logic [1:0] {
      VCMP_EDGE_BOTH = 2'h0,
      VCMP_EDGE_RSVD = 2'h1,
      VCMP_EDGE_FALL = 2'h2,
      VCMP_EDGE_RISE = 2'h3
   } vcmp_edge_t;

   typedef enum logic [1:0] {
      VCMP_SLP_ACTIVE  = 2'h0,
      VCMP_SLP_IDLE    = 2'h1,
      VCMP_SLP_STANDBY = 2'h2,
      VCMP_SLP_PWRDOWN = 2'h3
   } vcmp_sleep_t;

   typedef struct packed {
      logic       keep_running_in_standby;
      logic       pad_output_enable;
      vcmp_edge_t irq_edge_select;
      logic [1:0] hysteresis_select;
      logic       enable;
   } vcmp_ctrl_t;

   typedef struct packed {
      logic       invert;
      logic [1:0] positive_input_select;
      logic [1:0] negative_input_select;
   } vcmp_mux_t;

endpackage : vcmp_pkg

/* hdl/vcmp_channel.sv */
// One comparator channel: inversion, output gating, synchroniser, edge detect and flag.
// Assumes raw_cmp is the analog core result, synchronous to pclk as given.
`timescale 1ns/1ps
module vcmp_channel
   import vcmp_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       raw_cmp,
   input  vcmp_ctrl_t      ctrl,
   input  wire logic       invert,
   input  wire logic       core_on,
   input  wire logic       status_upd,
   input  wire logic       flag_clr,
   output logic            cmp_out,
   output logic            state_bit,
   output logic            flag
);

   logic       out_c;
   logic [2:0] sync_ff;
   logic       prev_ff;
   logic       flag_ff;
   logic       hit;

   // Inversion is applied once, ahead of every consumer.
   assign out_c   = core_on & (raw_cmp ^ invert);
   assign cmp_out = out_c;

   // Three stages give the documented three-cycle state delay.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_ff <= 3'h0;
      end else begin
         sync_ff <= {sync_ff[1:0], out_c};
      end
   end
   assign state_bit = sync_ff[2];

   // History keeps tracking in standby, so an edge seen while asleep raises no late flag on wake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= sync_ff[2];
      end
   end

   always_comb begin
      case (ctrl.irq_edge_select)
         VCMP_EDGE_BOTH: hit = sync_ff[2] ^ prev_ff;
         VCMP_EDGE_FALL: hit = prev_ff & ~sync_ff[2];
         VCMP_EDGE_RISE: hit = sync_ff[2] & ~prev_ff;
         default:        hit = 1'b0;
      endcase
   end

   // Set wins over a same-cycle clear so no edge is lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff <= 1'b0;
      end else if (status_upd && ctrl.enable && hit) begin
         flag_ff <= 1'b1;
      end else if (flag_clr) begin
         flag_ff <= 1'b0;
      end
   end
   assign flag = flag_ff;

   a_flag_set_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (status_upd && ctrl.enable && hit) |=> flag_ff)
      else $error("flag not set after edge");

   a_flag_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      (flag_clr && !(status_upd && ctrl.enable && hit)) |=> !flag_ff)
      else $error("flag not cleared by write of one");

   a_rsvd_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl.irq_edge_select == VCMP_EDGE_RSVD && !flag_ff) |=> !flag_ff)
      else $error("flag set under reserved edge code");

endmodule : vcmp_channel

/* hdl/vcmp_top.sv */
// Three voltage comparator controls behind one APB slave.
// Assumes the analog cores, pad mux, event router and irq controller sit outside.
// Functional notes
// - Core result is high only when positive input exceeds negative input.
// - Positive input from four pins; negative from two pins, converter or reference.
// - Two-bit hysteresis select: off, 10, 25 or 50 millivolts.
// - Pad output enable routes the comparator result to the pad.
// - Configured edge on the output sets the interrupt flag.
// - One irq enable bit gates the comparator interrupt source.
// - Irq asserted while flag and enable set, until flag cleared.
// - Enabled comparator always drives its output as an event.
// - In idle or any clocked sleep the comparator works normally.
// - Standby: off unless keep-running; then events and pad only update.
// - Power-down disables comparator and pad output.
// - Debug halt does not change comparator operation.
// - Three independent instances with own registers, irq and event.
// - Edge field: 0x0 both, 0x2 falling, 0x3 rising, 0x1 reserved.
// - Writing one to the flag clears it; zero leaves it.
// - State bit follows output through synchroniser, three cycles late.
// - Invert applies to pad, event, state bit and edge detection.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module vcmp_top
   import vcmp_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [VCMP_NUM_INST-1:0] raw_cmp,
   input  vcmp_sleep_t                   sleep_mode,
   input  wire logic                     debug_halt,
   output logic [VCMP_NUM_INST-1:0]      core_enable,
   output logic [VCMP_NUM_INST*2-1:0]    hysteresis_select,
   output logic [VCMP_NUM_INST*2-1:0]    positive_input_select,
   output logic [VCMP_NUM_INST*2-1:0]    negative_input_select,
   output logic [VCMP_NUM_INST-1:0]      pad_out,
   output logic [VCMP_NUM_INST-1:0]      pad_oe,
   output logic [VCMP_NUM_INST-1:0]      event_out,
   output logic [VCMP_NUM_INST-1:0]      compare_irq_vector
);

   vcmp_ctrl_t [VCMP_NUM_INST-1:0] ctrl_ff;
   vcmp_mux_t  [VCMP_NUM_INST-1:0] mux_ff;
   logic       [VCMP_NUM_INST-1:0] irqen_ff;
   logic       [VCMP_NUM_INST-1:0] cmp_c;
   logic       [VCMP_NUM_INST-1:0] state_c;
   logic       [VCMP_NUM_INST-1:0] flag_c;
   logic       [VCMP_NUM_INST-1:0] clr_c;
   logic       [VCMP_NUM_INST-1:0] core_on_c;
   logic                           in_stdby;
   logic                           in_pdown;
   logic                           status_upd;
   logic                           wr_acc;
   logic                           rd_acc;
   logic [1:0]                     inst_c;
   logic [3:0]                     idx_c;
   logic                           hit_c;
   logic [31:0]                    nxt_prdata;

   // Instance index sits in paddr[7:6], register index in paddr[5:2].
   function automatic logic [1:0] addr_inst(input logic [7:0] a);
      return a[7:6];
   endfunction : addr_inst

   function automatic logic [3:0] addr_idx(input logic [7:0] a);
      return a[5:2];
   endfunction : addr_idx

   assign inst_c = addr_inst(paddr);
   assign idx_c  = addr_idx(paddr);
   assign hit_c  = (inst_c < 2'(VCMP_NUM_INST)) && (paddr[1:0] == 2'h0) &&
                   ((idx_c == VCMP_IDX_CTRL) || (idx_c == VCMP_IDX_MUX) ||
                    (idx_c == VCMP_IDX_IRQEN) || (idx_c == VCMP_IDX_STATUS));
   // Zero wait states: access completes in its first access cycle.
   assign wr_acc = psel && penable && pwrite && hit_c;
   assign rd_acc = psel && !penable && !pwrite;

   // Debug halt is not an input of any gating term, so halt has no effect.
   assign in_stdby   = (sleep_mode == VCMP_SLP_STANDBY);
   assign in_pdown   = (sleep_mode == VCMP_SLP_PWRDOWN);
   // Flag setting is frozen in standby and power-down; idle and active keep running.
   assign status_upd = !in_stdby && !in_pdown;

   genvar g;
   generate
      for (g = 0; g < VCMP_NUM_INST; g++) begin : g_inst
         always_comb begin
            core_on_c[g] = ctrl_ff[g].enable && !in_pdown &&
                           (!in_stdby || ctrl_ff[g].keep_running_in_standby);
            clr_c[g] = wr_acc && (inst_c == 2'(g)) && (idx_c == VCMP_IDX_STATUS) &&
                       pwdata[VCMP_STAT_FLAG_BIT];
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_ff[g] <= {VCMP_CTRL_RST[VCMP_CTRL_STDBY_BIT], VCMP_CTRL_RST[VCMP_CTRL_PADEN_BIT],
                              VCMP_CTRL_RST[VCMP_CTRL_EDGE_LSB+:2], VCMP_CTRL_RST[VCMP_CTRL_HYS_LSB+:2],
                              VCMP_CTRL_RST[VCMP_CTRL_ENABLE_BIT]};
            end else if (wr_acc && inst_c == 2'(g) && idx_c == VCMP_IDX_CTRL) begin
               ctrl_ff[g] <= {pwdata[VCMP_CTRL_STDBY_BIT], pwdata[VCMP_CTRL_PADEN_BIT],
                              pwdata[VCMP_CTRL_EDGE_LSB+:2], pwdata[VCMP_CTRL_HYS_LSB+:2],
                              pwdata[VCMP_CTRL_ENABLE_BIT]};
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mux_ff[g] <= {VCMP_MUX_RST[VCMP_MUX_INV_BIT], VCMP_MUX_RST[VCMP_MUX_POS_LSB+:2],
                             VCMP_MUX_RST[VCMP_MUX_NEG_LSB+:2]};
            end else if (wr_acc && inst_c == 2'(g) && idx_c == VCMP_IDX_MUX) begin
               mux_ff[g] <= {pwdata[VCMP_MUX_INV_BIT], pwdata[VCMP_MUX_POS_LSB+:2],
                             pwdata[VCMP_MUX_NEG_LSB+:2]};
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irqen_ff[g] <= VCMP_IRQEN_RST[VCMP_IRQEN_BIT];
            end else if (wr_acc && inst_c == 2'(g) && idx_c == VCMP_IDX_IRQEN) begin
               irqen_ff[g] <= pwdata[VCMP_IRQEN_BIT];
            end
         end

         // The core's result already means positive above negative.
         vcmp_channel u_chan (
            .pclk       (pclk),
            .presetn    (presetn),
            .raw_cmp    (raw_cmp[g]),
            .ctrl       (ctrl_ff[g]),
            .invert     (mux_ff[g].invert),
            .core_on    (core_on_c[g]),
            .status_upd (status_upd),
            .flag_clr   (clr_c[g]),
            .cmp_out    (cmp_c[g]),
            .state_bit  (state_c[g]),
            .flag       (flag_c[g])
         );

         // Outputs are registered, adding one cycle after the core result.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               core_enable[g]               <= 1'b0;
               hysteresis_select[2*g+:2]     <= 2'h0;
               positive_input_select[2*g+:2] <= 2'h0;
               negative_input_select[2*g+:2] <= 2'h0;
            end else begin
               core_enable[g]               <= core_on_c[g];
               hysteresis_select[2*g+:2]     <= ctrl_ff[g].hysteresis_select;
               positive_input_select[2*g+:2] <= mux_ff[g].positive_input_select;
               negative_input_select[2*g+:2] <= mux_ff[g].negative_input_select;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pad_out[g]   <= 1'b0;
               pad_oe[g]    <= 1'b0;
               event_out[g] <= 1'b0;
            end else begin
               pad_oe[g]    <= ctrl_ff[g].pad_output_enable && core_on_c[g];
               pad_out[g]   <= cmp_c[g] && ctrl_ff[g].pad_output_enable;
               event_out[g] <= cmp_c[g];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               compare_irq_vector[g] <= 1'b0;
            end else begin
               compare_irq_vector[g] <= flag_c[g] && irqen_ff[g];
            end
         end

         a_irq_follows_flag: assert property (@(posedge pclk) disable iff (!presetn)
            ##1 (compare_irq_vector[g] == $past(flag_c[g] && irqen_ff[g])))
            else $error("irq does not follow flag and enable");

         a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
            !irqen_ff[g] |=> !compare_irq_vector[g])
            else $error("irq raised while its enable is off");

         a_event_when_off: assert property (@(posedge pclk) disable iff (!presetn)
            !ctrl_ff[g].enable |=> !event_out[g])
            else $error("event driven while disabled");

         a_event_stdby_off: assert property (@(posedge pclk) disable iff (!presetn)
            (in_stdby && !ctrl_ff[g].keep_running_in_standby) |=> !event_out[g])
            else $error("event driven in standby without keep running");

         a_pad_off_pdown: assert property (@(posedge pclk) disable iff (!presetn)
            in_pdown |=> !pad_oe[g])
            else $error("pad driven in power-down");

         a_core_off_pdown: assert property (@(posedge pclk) disable iff (!presetn)
            in_pdown |=> !core_enable[g])
            else $error("core powered in power-down");

         a_pad_gated: assert property (@(posedge pclk) disable iff (!presetn)
            !ctrl_ff[g].pad_output_enable |=> (!pad_out[g] && !pad_oe[g]))
            else $error("pad driven with pad output disabled");

         a_state_delay: assert property (@(posedge pclk) disable iff (!presetn)
            state_c[g] == $past(cmp_c[g], 3))
            else $error("state bit not three cycles behind");

         a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
            (clr_c[g] && !(status_upd && ctrl_ff[g].enable)) |=> !flag_c[g])
            else $error("flag not cleared by write of one");

         a_stdby_frozen: assert property (@(posedge pclk) disable iff (!presetn)
            (in_stdby && !flag_c[g]) |=> !flag_c[g])
            else $error("flag set during standby");

         a_event_runs: assert property (@(posedge pclk) disable iff (!presetn)
            (ctrl_ff[g].enable && sleep_mode != VCMP_SLP_PWRDOWN && sleep_mode != VCMP_SLP_STANDBY)
            |=> (event_out[g] == $past(raw_cmp[g] ^ mux_ff[g].invert)))
            else $error("event does not follow comparator");
      end
   endgenerate

   always_comb begin
      nxt_prdata = 32'h0;
      if (hit_c) begin
         case (idx_c)
            VCMP_IDX_CTRL: begin
               nxt_prdata[VCMP_CTRL_STDBY_BIT]    = ctrl_ff[inst_c].keep_running_in_standby;
               nxt_prdata[VCMP_CTRL_PADEN_BIT]    = ctrl_ff[inst_c].pad_output_enable;
               nxt_prdata[VCMP_CTRL_EDGE_LSB+:2]  = ctrl_ff[inst_c].irq_edge_select;
               nxt_prdata[VCMP_CTRL_HYS_LSB+:2]   = ctrl_ff[inst_c].hysteresis_select;
               nxt_prdata[VCMP_CTRL_ENABLE_BIT]   = ctrl_ff[inst_c].enable;
            end
            VCMP_IDX_MUX: begin
               nxt_prdata[VCMP_MUX_INV_BIT]       = mux_ff[inst_c].invert;
               nxt_prdata[VCMP_MUX_POS_LSB+:2]    = mux_ff[inst_c].positive_input_select;
               nxt_prdata[VCMP_MUX_NEG_LSB+:2]    = mux_ff[inst_c].negative_input_select;
            end
            VCMP_IDX_IRQEN: begin
               nxt_prdata[VCMP_IRQEN_BIT]         = irqen_ff[inst_c];
            end
            VCMP_IDX_STATUS: begin
               nxt_prdata[VCMP_STAT_STATE_BIT]    = state_c[inst_c];
               nxt_prdata[VCMP_STAT_FLAG_BIT]     = flag_c[inst_c];
            end
            default: nxt_prdata = 32'h0;
         endcase
      end
   end

   // Read data is captured at setup so it is stable through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_acc) begin
         prdata <= nxt_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit_c;
      end
   end

endmodule : vcmp_top

/* verification/vcmp_core_model.sv */
// Behavioural model of the three analog comparator cores that sit outside the control block.
// Assumes the bench sets the pin and internal source levels as small integers, changed only after a clock edge.
`timescale 1ns/1ps
module vcmp_core_model
   import vcmp_pkg::*;
(
   input  wire logic [VCMP_NUM_INST-1:0]   core_enable,
   input  wire logic [VCMP_NUM_INST*2-1:0] positive_input_select,
   input  wire logic [VCMP_NUM_INST*2-1:0] negative_input_select,
   input  wire logic [3:0][7:0]            pos_mv,
   input  wire logic [3:0][7:0]            neg_mv,
   output logic      [VCMP_NUM_INST-1:0]   raw_cmp
);
   // Negative index 2 stands for the internal reference and 3 for the converter output.
   // An unpowered core gives a low result, so a missing enable never looks like a valid compare.
   always_comb begin
      for (int i = 0; i < VCMP_NUM_INST; i++) begin
         raw_cmp[i] = core_enable[i] &&
                      (pos_mv[positive_input_select[2*i +: 2]] > neg_mv[negative_input_select[2*i +: 2]]);
      end
   end
endmodule : vcmp_core_model

/* verification/analog_comparator_control_tb.sv */
// Self-checking bench for the voltage comparator control block, driven over APB.
// Assumes the core model stands in for the analog cores; pins are shared by all three instances.
`timescale 1ns/1ps
module analog_comparator_control_tb;
   import vcmp_pkg::*;
   logic                       pclk = 1'b0;
   logic                       presetn = 1'b0;
   logic                       psel = 1'b0;
   logic                       penable = 1'b0;
   logic                       pwrite = 1'b0;
   logic [7:0]                 paddr = 8'h00;
   logic [31:0]                pwdata = 32'h0;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   logic [VCMP_NUM_INST-1:0]   raw_cmp;
   vcmp_sleep_t                sleep_mode = VCMP_SLP_ACTIVE;
   logic                       debug_halt = 1'b0;
   logic [VCMP_NUM_INST-1:0]   core_enable;
   logic [VCMP_NUM_INST*2-1:0] hysteresis_select;
   logic [VCMP_NUM_INST*2-1:0] positive_input_select;
   logic [VCMP_NUM_INST*2-1:0] negative_input_select;
   logic [VCMP_NUM_INST-1:0]   pad_out;
   logic [VCMP_NUM_INST-1:0]   pad_oe;
   logic [VCMP_NUM_INST-1:0]   event_out;
   logic [VCMP_NUM_INST-1:0]   compare_irq_vector;
   logic [3:0][7:0]            pos_mv = {4{8'h40}};
   logic [3:0][7:0]            neg_mv = {4{8'h50}};
   logic [31:0]                rdata;
   logic                       rerr;
   int                         num_errors = 0;
   int                         total_checks = 0;
   int                         cycles = 0;

   always #20 pclk = ~pclk;

   vcmp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .raw_cmp(raw_cmp), .sleep_mode(sleep_mode), .debug_halt(debug_halt), .core_enable(core_enable),
      .hysteresis_select(hysteresis_select), .positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .pad_out(pad_out), .pad_oe(pad_oe),
      .event_out(event_out), .compare_irq_vector(compare_irq_vector));

   vcmp_core_model core_u (.core_enable(core_enable), .positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .pos_mv(pos_mv), .neg_mv(neg_mv), .raw_cmp(raw_cmp));

   task give_verdict;
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check

   // Entered just after a rising edge; leaves one idle cycle so strobes never change twice in a step.
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      xfer(a, 1'b0, 32'h0);
      check(rdata, exp, "read data");
      check(32'(rerr), 32'(err), "slave error");
   endtask : rd

   // Moves one positive pin and gives the synchroniser, flag and irq stages time to settle.
   task lvl(input int i, input logic [7:0] v);
      pos_mv[i] <= v;
      repeat (8) @(posedge pclk);
   endtask : lvl

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h08, 32'h0, 1'b0);
      rd(8'h18, 32'h0, 1'b0);
      rd(8'h1c, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      rd(8'hc0, 32'h0, 1'b1);
      rd(8'h01, 32'h0, 1'b1);
      wr(8'h08, 32'h08);
      wr(8'h00, 32'h75);
      repeat (70) @(posedge pclk);
      check(32'({core_enable[0], pad_oe[0], hysteresis_select[1:0], positive_input_select[1:0],
                 negative_input_select[1:0]}), 32'b1_1_10_01_00, "configuration outputs");
      for (int h = 0; h < 4; h++) begin
         wr(8'h00, 32'h71 | (h << 1));
         // The registered copy moves one edge after the write lands.
         @(posedge pclk);
         check(32'(hysteresis_select[1:0]), h, "hysteresis code");
      end
      lvl(1, 8'h60);
      check(32'({event_out[0], pad_out[0], compare_irq_vector[0]}), 32'b110, "output high");
      rd(8'h1c, 32'h11, 1'b0);
      wr(8'h18, 32'h1);
      repeat (2) @(posedge pclk);
      check(32'(compare_irq_vector[0]), 32'h1, "irq raised");
      wr(8'h1c, 32'h0);
      rd(8'h1c, 32'h11, 1'b0);
      check(32'(compare_irq_vector[0]), 32'h1, "irq held");
      wr(8'h1c, 32'h1);
      repeat (2) @(posedge pclk);
      check(32'(compare_irq_vector[0]), 32'h0, "irq dropped");
      rd(8'h1c, 32'h10, 1'b0);
      for (int e = 0; e < 4; e++) begin
         wr(8'h00, 32'h41 | (e << 4));
         wr(8'h1c, 32'h1);
         lvl(1, 8'h40);
         rd(8'h1c, 32'((e == 0) || (e == 2)), 1'b0);
         wr(8'h1c, 32'h1);
         lvl(1, 8'h60);
         rd(8'h1c, 32'h10 | 32'((e == 0) || (e == 3)), 1'b0);
      end
      wr(8'h1c, 32'h1);
      wr(8'h08, 32'h88);
      repeat (8) @(posedge pclk);
      check(32'({event_out[0], pad_out[0]}), 32'b00, "inverted low");
      rd(8'h1c, 32'h00, 1'b0);
      lvl(1, 8'h40);
      check(32'({event_out[0], pad_out[0]}), 32'b11, "inverted high");
      rd(8'h1c, 32'h11, 1'b0);
      wr(8'h08, 32'h08);
      wr(8'h1c, 32'h1);
      sleep_mode <= VCMP_SLP_IDLE;
      lvl(1, 8'h60);
      rd(8'h1c, 32'h11, 1'b0);
      wr(8'h1c, 32'h1);
      debug_halt <= 1'b1;
      lvl(1, 8'h40);
      lvl(1, 8'h60);
      rd(8'h1c, 32'h11, 1'b0);
      wr(8'h1c, 32'h1);
      debug_halt <= 1'b0;
      sleep_mode <= VCMP_SLP_STANDBY;
      repeat (4) @(posedge pclk);
      check(32'(core_enable[0]), 32'h0, "standby halt");
      sleep_mode <= VCMP_SLP_ACTIVE;
      wr(8'h00, 32'hf1);
      sleep_mode <= VCMP_SLP_STANDBY;
      lvl(1, 8'h40);
      check(32'({core_enable[0], event_out[0], pad_out[0]}), 32'b100, "standby low");
      lvl(1, 8'h60);
      check(32'({event_out[0], pad_out[0]}), 32'b11, "standby high");
      sleep_mode <= VCMP_SLP_ACTIVE;
      repeat (8) @(posedge pclk);
      rd(8'h1c, 32'h10, 1'b0);
      sleep_mode <= VCMP_SLP_PWRDOWN;
      repeat (8) @(posedge pclk);
      check(32'({core_enable[0], pad_oe[0], event_out[0]}), 32'b000, "power down");
      sleep_mode <= VCMP_SLP_ACTIVE;
      wr(8'h00, 32'h70);
      lvl(1, 8'h40);
      lvl(1, 8'h60);
      check(32'(event_out[0]), 32'h0, "disabled event");
      rd(8'h1c, 32'h00, 1'b0);
      wr(8'h48, 32'h10);
      wr(8'h40, 32'h31);
      wr(8'h58, 32'h1);
      repeat (70) @(posedge pclk);
      lvl(2, 8'h60);
      check(32'(compare_irq_vector), 32'b010, "second instance irq");
      check(32'(event_out), 32'b010, "second instance event");
      rd(8'h5c, 32'h11, 1'b0);
      rd(8'h1c, 32'h00, 1'b0);
      give_verdict();
   end
endmodule : analog_comparator_control_tb
